// >>> pkg/cfd_pkg.sv
// Shared constants and state types for the clock fanout divider control block
package cfd_pkg;
    localparam int       FRAME_BITS   = 24;
    localparam int       ADDR_BITS    = 7;
    localparam int       DATA_BITS    = 16;
    localparam int       NUM_OUTS     = 4;
    localparam int       TEMP_BITS    = 10;
    localparam int       CNT_BITS     = 13;
    localparam logic [4:0] ADDR_END   = 5'h08;
    localparam logic [4:0] FRAME_END  = 5'h18;
    // Register addresses
    localparam logic [6:0] ADDR_CTRL  = 7'h00;
    localparam logic [6:0] ADDR_OUT   = 7'h01;
    localparam logic [6:0] ADDR_MAIN  = 7'h02;
    localparam logic [6:0] ADDR_AUX   = 7'h03;
    localparam logic [6:0] ADDR_TEMP  = 7'h04;
    // Field positions
    localparam int       CTRL_RESET_BIT = 0;
    localparam int       CTRL_RBEN_BIT  = 1;
    localparam int       OUT_PWR_LSB    = 0;
    localparam int       OUT_EN_LSB     = 12;
    localparam int       MAIN_MUX_BIT   = 0;
    localparam int       MAIN_DIV_LSB   = 1;
    localparam int       MAIN_RST_BIT   = 4;
    localparam int       AUX_PRE_LSB    = 0;
    localparam int       AUX_DIV_LSB    = 2;
    // Reset values
    localparam logic       RBEN_RST     = 1'b1;
    localparam logic [3:0] OUT_EN_RST   = 4'hf;
    localparam logic [2:0] OUT_PWR_RST  = 3'h7;
    localparam logic       MUX_RST      = 1'b0;
    localparam logic [2:0] DIV_RST      = 3'h1;
    localparam logic       DIVRST_RST   = 1'b0;
    localparam logic [1:0] AUX_PRE_RST  = 2'h0;
    localparam logic [9:0] AUX_DIV_RST  = 10'h001;
    // Serial timing seen by the core clock
    localparam int       CORE_MHZ       = 50;
    localparam int       SPI_FMAX_MHZ   = 2;
    localparam int       SCK_MIN_CYC    = CORE_MHZ / SPI_FMAX_MHZ;

    typedef struct packed {
        logic                      sw_rst;
        logic                      rb_en;
        logic [NUM_OUTS-1:0]       out_en;
        logic [NUM_OUTS-1:0][2:0]  out_pwr;
        logic                      mux;
        logic [2:0]                div;
        logic                      div_rst;
        logic [1:0]                aux_pre;
        logic [9:0]                aux_div;
    } cfd_cfg_t;

    typedef struct packed {
        logic sck_meta;
        logic sck_sync;
        logic sck_prev;
        logic cs_meta;
        logic cs_sync;
        logic cs_prev;
        logic sdi_meta;
        logic sdi_sync;
    } cfd_link_t;

    typedef struct packed {
        logic [4:0]            cnt;
        logic [FRAME_BITS-1:0] shreg;
        logic                  rd;
        logic [DATA_BITS-1:0]  shadow;
        logic                  rb_out;
    } cfd_frame_t;

    typedef struct packed {
        logic [CNT_BITS-1:0]       main_cnt;
        logic [CNT_BITS-1:0]       aux_cnt;
        logic [NUM_OUTS-1:0]       main_out;
        logic                      aux_out;
        logic [NUM_OUTS-1:0][2:0]  pwr;
    } cfd_div_t;

    typedef struct packed {
        cfd_cfg_t   cfg;
        cfd_link_t  lk;
        cfd_frame_t fr;
        cfd_div_t   dv;
    } cfd_state_t;
endpackage

// >>> verilog/cfd_clock_fanout_ctrl.sv
// Serial control port, register file and clock dividers of the fanout block
// Operation
// [RULE1] Host writes with leading flag zero
// [RULE2] Data sampled on every serial clock rise
// [RULE3] Clock edges count only while select low
// [RULE4] Host uses clock idle low, rise sampling
// [RULE5] Host keeps unaddressed devices deselected
// [RULE6] Host reads with leading flag one
// [RULE7] Readback held low during address bits
// [RULE8] Readback bits shift out on falling edges
// [RULE9] Data input ignored during read data
// [RULE10] Readback stays driven until enable cleared
// [RULE11] Readback shows effective, not written, state
// [RULE12] Power-up resets everything; dividers bypassed
// [RULE13] Host waits 100 us after power-up
// [RULE14] Reset bit resets all; clears on writes
// [RULE15] Software reset finishes before next write
// [RULE16] Temperature code is readable
// [RULE17] Four main outputs share one divider
// [RULE18] Per-output enable and power level 0-7
// [RULE19] Path select: 0 bypass, 1 divide
// [RULE20] Divide codes 1-7 give 2-8, odd duty
// [RULE21] Host toggles restart after input change
// [RULE22] Auxiliary pre-divider times 1-1023 divider
// [RULE23] Host serial clock at most 2 MHz
// [RULE24] Frame: flag, 7 address, 16 data bits
// [RULE25] Frames of wrong length are discarded
module cfd_clock_fanout_ctrl #(
    parameter int TEMP_W = cfd_pkg::TEMP_BITS
) (
    input  wire logic                                CORE_CLK,
    input  wire logic                                RESET,
    input  wire logic                                SCK,
    input  wire logic                                SDI,
    input  wire logic                                CS_N,
    input  wire logic [TEMP_W-1:0]                   TEMP_CODE,
    output logic                                     READBACK_OUT_PIN,
    output logic                                     READBACK_OUT_OE,
    output logic [cfd_pkg::NUM_OUTS-1:0]             MAIN_CLOCK_OUTPUT,
    output logic [cfd_pkg::NUM_OUTS-1:0][2:0]        MAIN_OUTPUT_POWER_LEVEL,
    output logic                                     AUXILIARY_CLOCK_OUTPUT
);

    if (TEMP_W < 1 || TEMP_W > cfd_pkg::DATA_BITS) begin : g_chk
        $error("TEMP_W must lie between 1 and the data width");
    end

    // The 50 MHz core must see each serial clock phase several times
    if (cfd_pkg::SCK_MIN_CYC < 8) begin : g_rate
        $error("Core clock too slow for the serial port");
    end

    // Field slices below assume four outputs of three power bits each
    if (cfd_pkg::NUM_OUTS != 4) begin : g_outs
        $error("Four main outputs are assumed by the register layout");
    end

    // The frame decode is wired for one flag, 7 address and 16 data bits
    if (cfd_pkg::FRAME_BITS != 1 + cfd_pkg::ADDR_BITS + cfd_pkg::DATA_BITS) begin : g_frame
        $error("Frame length must equal flag, address and data bits");
    end

    // Twice the largest auxiliary ratio must fit the 13-bit tick counters
    if (cfd_pkg::CNT_BITS != 13) begin : g_cnt
        $error("Divider counters must be 13 bits wide");
    end

    cfd_pkg::cfd_state_t s_ff;
    cfd_pkg::cfd_state_t nxt_s;

    // Configuration after power-up or software reset
    function automatic cfd_pkg::cfd_cfg_t cfg_default();
        cfd_pkg::cfd_cfg_t c;
        c.sw_rst  = 1'b0;
        c.rb_en   = cfd_pkg::RBEN_RST;
        c.out_en  = cfd_pkg::OUT_EN_RST;
        for (int i = 0; i < cfd_pkg::NUM_OUTS; i++) begin
            c.out_pwr[i] = cfd_pkg::OUT_PWR_RST;
        end
        c.mux     = cfd_pkg::MUX_RST;
        c.div     = cfd_pkg::DIV_RST;
        c.div_rst = cfd_pkg::DIVRST_RST;
        c.aux_pre = cfd_pkg::AUX_PRE_RST;
        c.aux_div = cfd_pkg::AUX_DIV_RST;
        return c;
    endfunction

    // Ticks per output period are twice the ratio: one tick per input half cycle
    function automatic logic [cfd_pkg::CNT_BITS-1:0] high_ticks(
        input logic [cfd_pkg::CNT_BITS-1:0] t
    );
        logic [cfd_pkg::CNT_BITS-1:0] h;
        h = {t[cfd_pkg::CNT_BITS-1:1], 1'b0};
        if (t == 13'h0001) begin
            h = 13'h0001;
        end
        return h;
    endfunction

    function automatic logic [cfd_pkg::CNT_BITS-1:0] last_tick(
        input logic [cfd_pkg::CNT_BITS-1:0] t
    );
        return {t[cfd_pkg::CNT_BITS-2:0], 1'b0} - 13'h0001;
    endfunction

    // Readback of the live state rather than the written word
    function automatic logic [cfd_pkg::DATA_BITS-1:0] rd_word(
        input logic [6:0]          a,
        input cfd_pkg::cfd_state_t st,
        input logic [TEMP_W-1:0]   temp
    );
        logic [cfd_pkg::DATA_BITS-1:0] w;
        w = 16'h0000;
        unique case (a)
            cfd_pkg::ADDR_CTRL: begin
                w[cfd_pkg::CTRL_RESET_BIT] = st.cfg.sw_rst;
                w[cfd_pkg::CTRL_RBEN_BIT]  = st.cfg.rb_en;
            end
            cfd_pkg::ADDR_OUT: begin
                w[cfd_pkg::OUT_EN_LSB +: 4] = st.cfg.out_en;
                w[cfd_pkg::OUT_PWR_LSB +: 12] = st.dv.pwr; // [RULE11]
            end
            cfd_pkg::ADDR_MAIN: begin
                w[cfd_pkg::MAIN_MUX_BIT]     = st.cfg.mux;
                w[cfd_pkg::MAIN_DIV_LSB +: 3] = st.cfg.div;
                w[cfd_pkg::MAIN_RST_BIT]     = st.cfg.div_rst;
            end
            cfd_pkg::ADDR_AUX: begin
                w[cfd_pkg::AUX_PRE_LSB +: 2]  = st.cfg.aux_pre;
                w[cfd_pkg::AUX_DIV_LSB +: 10] = st.cfg.aux_div;
            end
            cfd_pkg::ADDR_TEMP: begin
                w[TEMP_W-1:0] = temp; // [RULE16]
            end
            default: begin
                w = 16'h0000;
            end
        endcase
        return w;
    endfunction

    logic                          sck_rise;
    logic                          sck_fall;
    logic                          cs_rise;
    logic [6:0]                    addr_now;
    logic [6:0]                    wr_addr;
    logic [cfd_pkg::DATA_BITS-1:0] wr_data;
    logic [cfd_pkg::CNT_BITS-1:0]  main_ratio;
    logic [cfd_pkg::CNT_BITS-1:0]  aux_ratio;
    logic [1:0]                    pre_shift;
    logic [9:0]                    aux_div_eff;
    logic                          main_hold;
    logic                          main_phase;
    logic                          aux_phase;
    logic                          sw_hit;

    always_comb begin
        nxt_s = s_ff;
        sw_hit = 1'b0;

        // Two-flop synchronisers; edge logic reads only the second and third stages
        nxt_s.lk.sck_meta = SCK;
        nxt_s.lk.sck_sync = s_ff.lk.sck_meta;
        nxt_s.lk.sck_prev = s_ff.lk.sck_sync;
        nxt_s.lk.cs_meta  = CS_N;
        nxt_s.lk.cs_sync  = s_ff.lk.cs_meta;
        nxt_s.lk.cs_prev  = s_ff.lk.cs_sync;
        nxt_s.lk.sdi_meta = SDI;
        nxt_s.lk.sdi_sync = s_ff.lk.sdi_meta;

        sck_rise = s_ff.lk.sck_sync & ~s_ff.lk.sck_prev & ~s_ff.lk.cs_sync; // [RULE3]
        sck_fall = ~s_ff.lk.sck_sync & s_ff.lk.sck_prev & ~s_ff.lk.cs_sync; // [RULE3]
        cs_rise  = s_ff.lk.cs_sync & ~s_ff.lk.cs_prev;

        addr_now = {s_ff.fr.shreg[5:0], s_ff.lk.sdi_sync};
        wr_addr  = s_ff.fr.shreg[22:16];
        wr_data  = s_ff.fr.shreg[15:0];

        if (sck_rise) begin
            nxt_s.fr.shreg = {s_ff.fr.shreg[22:0], s_ff.lk.sdi_sync}; // [RULE2]
            if (s_ff.fr.cnt != 5'h1f) begin
                nxt_s.fr.cnt = s_ff.fr.cnt + 5'h01;
            end
            if (s_ff.fr.cnt == cfd_pkg::ADDR_END - 5'h01) begin
                // Flag bit sits six places up once the address is complete
                nxt_s.fr.rd = s_ff.fr.shreg[6]; // [RULE6]
                if (s_ff.fr.shreg[6]) begin
                    nxt_s.fr.shadow = rd_word(addr_now, s_ff, TEMP_CODE); // [RULE11]
                end
            end
        end

        if (~s_ff.lk.cs_sync && s_ff.fr.cnt < cfd_pkg::ADDR_END) begin
            nxt_s.fr.rb_out = 1'b0; // [RULE7]
        end else if (sck_fall && s_ff.fr.rd && s_ff.fr.cnt < cfd_pkg::FRAME_END) begin
            nxt_s.fr.rb_out = s_ff.fr.shadow[cfd_pkg::DATA_BITS-1]; // [RULE8]
            nxt_s.fr.shadow = {s_ff.fr.shadow[cfd_pkg::DATA_BITS-2:0], 1'b0};
        end

        // Between frames the count is cleared; a partial frame leaves no count or read flag behind
        if (s_ff.lk.cs_sync) begin
            nxt_s.fr.cnt = 5'h00;
            nxt_s.fr.rd  = 1'b0;
        end

        // Commit only a full write frame, read frames ignore their data bits
        if (cs_rise && s_ff.fr.cnt == cfd_pkg::FRAME_END
            && !s_ff.fr.shreg[cfd_pkg::FRAME_BITS-1]) begin // [RULE1] [RULE9] [RULE24] [RULE25]
            nxt_s.cfg.sw_rst = 1'b0; // [RULE14]
            unique case (wr_addr)
                cfd_pkg::ADDR_CTRL: begin
                    nxt_s.cfg.rb_en = wr_data[cfd_pkg::CTRL_RBEN_BIT]; // [RULE10]
                    if (wr_data[cfd_pkg::CTRL_RESET_BIT]) begin
                        // Completes in one core cycle, far inside one serial bit
                        nxt_s.cfg        = cfg_default(); // [RULE14] [RULE15]
                        nxt_s.cfg.sw_rst = 1'b1;
                        sw_hit           = 1'b1;
                    end
                end
                cfd_pkg::ADDR_OUT: begin
                    nxt_s.cfg.out_en  = wr_data[cfd_pkg::OUT_EN_LSB +: 4];
                    nxt_s.cfg.out_pwr = wr_data[cfd_pkg::OUT_PWR_LSB +: 12];
                end
                cfd_pkg::ADDR_MAIN: begin
                    nxt_s.cfg.mux     = wr_data[cfd_pkg::MAIN_MUX_BIT];
                    nxt_s.cfg.div     = wr_data[cfd_pkg::MAIN_DIV_LSB +: 3];
                    nxt_s.cfg.div_rst = wr_data[cfd_pkg::MAIN_RST_BIT];
                end
                cfd_pkg::ADDR_AUX: begin
                    nxt_s.cfg.aux_pre = wr_data[cfd_pkg::AUX_PRE_LSB +: 2];
                    nxt_s.cfg.aux_div = wr_data[cfd_pkg::AUX_DIV_LSB +: 10];
                end
                default: begin
                    nxt_s.cfg.sw_rst = 1'b0;
                end
            endcase
        end

        // One shared ratio for all four main outputs
        main_ratio = 13'h0001; // [RULE19]
        if (s_ff.cfg.mux) begin
            main_ratio = {10'h000, s_ff.cfg.div} + 13'h0001; // [RULE20]
        end
        // Reserved code 0 and the restart bit both park the divider low
        main_hold = s_ff.cfg.div_rst || (s_ff.cfg.mux && s_ff.cfg.div == 3'h0); // [RULE20]

        if (main_hold) begin
            nxt_s.dv.main_cnt = '0;
        end else if (s_ff.dv.main_cnt >= last_tick(main_ratio)) begin
            nxt_s.dv.main_cnt = '0;
        end else begin
            nxt_s.dv.main_cnt = s_ff.dv.main_cnt + 13'h0001;
        end
        main_phase = !main_hold && (s_ff.dv.main_cnt < high_ticks(main_ratio));

        for (int i = 0; i < cfd_pkg::NUM_OUTS; i++) begin
            nxt_s.dv.main_out[i] = s_ff.cfg.out_en[i] & main_phase; // [RULE17]
            // Power setting is meaningless while the output is off
            nxt_s.dv.pwr[i] = s_ff.cfg.out_en[i] ? s_ff.cfg.out_pwr[i] : 3'h0; // [RULE18]
        end

        // Codes above 2 select the largest pre-divider
        pre_shift   = (s_ff.cfg.aux_pre > 2'h2) ? 2'h2 : s_ff.cfg.aux_pre;
        aux_div_eff = (s_ff.cfg.aux_div == 10'h000) ? 10'h001 : s_ff.cfg.aux_div;
        aux_ratio   = {3'h0, aux_div_eff} << pre_shift; // [RULE22]

        if (s_ff.dv.aux_cnt >= last_tick(aux_ratio)) begin
            nxt_s.dv.aux_cnt = '0;
        end else begin
            nxt_s.dv.aux_cnt = s_ff.dv.aux_cnt + 13'h0001;
        end
        aux_phase = s_ff.dv.aux_cnt < high_ticks(aux_ratio); // [RULE22]
        nxt_s.dv.aux_out = aux_phase;

        // Applied last so the divider updates above cannot undo the restart
        if (sw_hit) begin
            nxt_s.dv = '0; // [RULE14]
        end
    end

    // Power-up reset bypasses the dividers and enables every output
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            s_ff.cfg    <= cfg_default(); // [RULE12]
            s_ff.lk     <= '0;
            s_ff.lk.cs_meta <= 1'b1;
            s_ff.lk.cs_sync <= 1'b1;
            s_ff.lk.cs_prev <= 1'b1;
            s_ff.fr     <= '0;
            s_ff.dv     <= '0; // [RULE12]
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign READBACK_OUT_PIN        = s_ff.fr.rb_out;
    assign READBACK_OUT_OE         = s_ff.cfg.rb_en; // [RULE10]
    assign MAIN_CLOCK_OUTPUT       = s_ff.dv.main_out;
    assign MAIN_OUTPUT_POWER_LEVEL = s_ff.dv.pwr;
    assign AUXILIARY_CLOCK_OUTPUT  = s_ff.dv.aux_out;

endmodule // cfd_clock_fanout_ctrl

// >>> test/cfd_checker.sv
// Port-level assertions for the fanout control block
module cfd_checker (
    input wire logic            CORE_CLK,
    input wire logic            RESET,
    input wire logic            CS_N,
    input wire logic            SCK,
    input wire logic            READBACK_OUT_PIN,
    input wire logic            READBACK_OUT_OE,
    input wire logic [3:0]      MAIN_CLOCK_OUTPUT,
    input wire logic [3:0][2:0] MAIN_OUTPUT_POWER_LEVEL,
    input wire logic            AUXILIARY_CLOCK_OUTPUT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] main_q;
    logic [3:0] hi_cnt;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    // Saturating run length of output 0 high time
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            main_q <= 4'h0;
            hi_cnt <= 4'h0;
        end else begin
            main_q <= MAIN_CLOCK_OUTPUT;
            hi_cnt <= !MAIN_CLOCK_OUTPUT[0] ? 4'h0 : (hi_cnt == 4'hf) ? hi_cnt : hi_cnt + 4'h1;
        end
    end
    rst_vals_a: assert property (disable iff (1'b0)
        RESET && $past(RESET) |-> READBACK_OUT_OE && !READBACK_OUT_PIN && MAIN_CLOCK_OUTPUT == 4'h0
        && !AUXILIARY_CLOCK_OUTPUT && MAIN_OUTPUT_POWER_LEVEL == 12'h000) else $error("reset values");
    byp_start_a: assert property ($fell(RESET) |-> ##[1:3] MAIN_CLOCK_OUTPUT == 4'hf
        ##1 MAIN_CLOCK_OUTPUT == 4'h0) else $error("no bypass after reset");
    aux_start_a: assert property ($fell(RESET) |-> ##[1:3] AUXILIARY_CLOCK_OUTPUT
        ##1 !AUXILIARY_CLOCK_OUTPUT) else $error("aux not bypassed after reset");
    rb_hold_a: assert property (CS_N [*5] |-> $stable(READBACK_OUT_PIN))
        else $error("readback moved while deselected");
    rb_sel_a: assert property ($changed(READBACK_OUT_PIN) |-> !$past(CS_N, 3))
        else $error("readback moved outside a frame");
    rb_fall_a: assert property (SCK [*6] |-> $stable(READBACK_OUT_PIN) || !READBACK_OUT_PIN)
        else $error("readback bit changed while clock high");
    main_same_a: assert property (!(|(MAIN_CLOCK_OUTPUT & ~main_q)
        && |(~MAIN_CLOCK_OUTPUT & main_q))) else $error("main outputs out of step");
    hi_max_a: assert property (hi_cnt <= 4'h8) else $error("main high time too long");
    cover property ($rose(READBACK_OUT_PIN));
    cover property (!READBACK_OUT_OE);
    cover property (hi_cnt == 4'h8);
endmodule // cfd_checker

bind cfd_clock_fanout_ctrl cfd_checker chk_i (
    .CORE_CLK(CORE_CLK),
    .RESET(RESET),
    .CS_N(CS_N),
    .SCK(SCK),
    .READBACK_OUT_PIN(READBACK_OUT_PIN),
    .READBACK_OUT_OE(READBACK_OUT_OE),
    .MAIN_CLOCK_OUTPUT(MAIN_CLOCK_OUTPUT),
    .MAIN_OUTPUT_POWER_LEVEL(MAIN_OUTPUT_POWER_LEVEL),
    .AUXILIARY_CLOCK_OUTPUT(AUXILIARY_CLOCK_OUTPUT)
);

// >>> test/cfd_host_model.sv
// Behavioural host controller on the serial control port
module cfd_host_model (
    input  wire logic clk,
    input  wire logic rb,
    output logic      sck,
    output logic      sdi,
    output logic      cs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        cs_n = 1'b1;
    end
    // 13 core cycles a half period keeps the link below 2 MHz
    task automatic half();
        repeat (13) @(posedge clk);
        #1;
    endtask
    task automatic xfer(input logic r, input logic [6:0] a, input logic [15:0] d,
                        input int n, output logic [15:0] q, output logic z);
        logic [23:0] w;
        w = {r, a, d};
        q = 16'h0000;
        z = 1'b0;
        @(posedge clk);
        #1 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi = w[23 - (i % 24)];
            half();
            sck = 1'b1;
            // First sample skipped: it is taken on the flag bit, not on an address bit
            if (i > 0 && i < 8) z = z | rb;
            else if (i >= 8) q = {q[14:0], rb};
            half();
            sck = 1'b0;
        end
        half();
        cs_n = 1'b1;
        sdi = ~sdi;
        repeat (6) @(posedge clk);
    endtask
    task automatic stray(input int n);
        repeat (n) begin
            half();
            sck = 1'b1;
            half();
            sck = 1'b0;
        end
    endtask
endmodule // cfd_host_model

// >>> test/tb.sv
// Self-checking bench for the fanout control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic            core_clk;
    logic            reset;
    logic            sck;
    logic            sdi;
    logic            cs_n;
    logic [9:0]      temp_code;
    logic            rb_pin;
    logic            rb_oe;
    logic [3:0]      main_clk;
    logic [3:0][2:0] main_pwr;
    logic            aux_clk;
    logic [15:0]     q;
    logic            z;
    int              fails;
    int              comparisons;
    int              p;
    int              h;
    int              t;
    int              pre_v [5] = '{0, 1, 2, 3, 0};
    int              div_v [5] = '{3, 5, 7, 1, 1023};
    cfd_clock_fanout_ctrl uut (.CORE_CLK(core_clk), .RESET(reset), .SCK(sck), .SDI(sdi),
        .CS_N(cs_n), .TEMP_CODE(temp_code), .READBACK_OUT_PIN(rb_pin), .READBACK_OUT_OE(rb_oe),
        .MAIN_CLOCK_OUTPUT(main_clk), .MAIN_OUTPUT_POWER_LEVEL(main_pwr),
        .AUXILIARY_CLOCK_OUTPUT(aux_clk));
    // A released readback line shows the inverse so a read without drive fails
    cfd_host_model host (.clk(core_clk), .rb(rb_oe ? rb_pin : ~rb_pin), .sck(sck), .sdi(sdi),
        .cs_n(cs_n));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n = 24);
        logic [15:0] dq;
        logic        dz;
        host.xfer(1'b0, a, d, n, dq, dz);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        host.xfer(1'b1, a, 16'hffff, 24, q, z);
        chk({15'h0000, z}, 16'h0000);
        chk(q, exp);
    endtask
    // Skips one whole period so a divider change settles before timing
    task automatic meas(input logic sel);
        int   r;
        int   t0;
        logic pv;
        logic v;
        r = 0;
        t0 = 0;
        p = 0;
        h = 0;
        pv = 1'b1;
        for (int n = 0; n < 20000 && r < 3; n++) begin
            @(posedge core_clk);
            #2 v = sel ? aux_clk : main_clk[0];
            if (v && !pv) begin
                r++;
                if (r == 2) t0 = n;
                if (r == 3) p = n - t0;
            end
            if (r == 2 && v) h++;
            pv = v;
        end
        if (r < 3) begin
            chk(16'(r), 16'h0003);
            summarize();
        end
    endtask
    task automatic low(input logic [3:0] m);
        repeat (8) begin
            @(posedge core_clk);
            chk({12'h000, main_clk & m}, 16'h0000);
        end
    endtask
    function automatic int hi_of(input int k);
        return (k == 1) ? 1 : 2 * (k / 2);
    endfunction
    initial begin
        reset = 1'b1;
        temp_code = 10'h2a5;
        repeat (12) @(posedge core_clk);
        #1 reset = 1'b0;
        repeat (5000) @(posedge core_clk);
        meas(1'b0);
        chk(16'(p), 16'h0002);
        chk(16'(h), 16'h0001);
        chk(16'(main_pwr), 16'h0fff);
        rd(cfd_pkg::ADDR_CTRL, 16'h0002);
        rd(cfd_pkg::ADDR_OUT, 16'hffff);
        rd(cfd_pkg::ADDR_MAIN, 16'h0002);
        rd(cfd_pkg::ADDR_AUX, 16'h0004);
        rd(cfd_pkg::ADDR_TEMP, 16'h02a5);
        rd(7'h7f, 16'h0000);
        $display("test defaults done");
        for (int c = 1; c < 8; c++) begin
            wr(cfd_pkg::ADDR_MAIN, 16'(2 * c + 1));
            meas(1'b0);
            chk(16'(p), 16'(2 * c + 2));
            chk(16'(h), 16'(hi_of(c + 1)));
        end
        wr(cfd_pkg::ADDR_MAIN, 16'h0013);
        low(4'hf);
        wr(cfd_pkg::ADDR_MAIN, 16'h0003);
        meas(1'b0);
        chk(16'(p), 16'h0004);
        $display("test main divider done");
        wr(cfd_pkg::ADDR_OUT, 16'hac2b);
        chk(16'(main_pwr), 16'h0c28);
        low(4'h5);
        rd(cfd_pkg::ADDR_OUT, 16'hac28);
        wr(cfd_pkg::ADDR_OUT, 16'h0000, 23);
        wr(cfd_pkg::ADDR_OUT, 16'h0000, 25);
        host.stray(5);
        rd(cfd_pkg::ADDR_OUT, 16'hac28);
        $display("test outputs and framing done");
        wr(cfd_pkg::ADDR_CTRL, 16'h0001);
        chk(16'(main_pwr), 16'h0fff);
        rd(cfd_pkg::ADDR_CTRL, 16'h0003);
        rd(cfd_pkg::ADDR_MAIN, 16'h0002);
        wr(cfd_pkg::ADDR_CTRL, 16'h0001);
        wr(cfd_pkg::ADDR_OUT, 16'h7fff);
        rd(cfd_pkg::ADDR_OUT, 16'h71ff);
        rd(cfd_pkg::ADDR_CTRL, 16'h0002);
        wr(cfd_pkg::ADDR_CTRL, 16'h0000);
        chk({15'h0000, rb_oe}, 16'h0000);
        wr(cfd_pkg::ADDR_CTRL, 16'h0002);
        chk({15'h0000, rb_oe}, 16'h0001);
        $display("test reset and drive enable done");
        for (int i = 0; i < 5; i++) begin
            t = (1 << ((pre_v[i] == 3) ? 2 : pre_v[i])) * div_v[i];
            wr(cfd_pkg::ADDR_AUX, {4'h0, 10'(div_v[i]), 2'(pre_v[i])});
            meas(1'b1);
            chk(16'(p), 16'(2 * t));
            chk(16'(h), 16'(hi_of(t)));
        end
        $display("test auxiliary divider done");
        summarize();
    end
endmodule // tb
